// [eeprom_bus_master.sv]
// two-wire bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
`default_nettype none
module eeprom_bus_master (
    input wire logic ref_clk,  // block clock that paces the bus
    input wire logic sda_line, // resolved data line level
    output var logic scl,      // serial clock, stands high outside frames
    output var logic sda_low   // high while the master pulls data low
);
    // bus idles released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // wait n block cycles, then step just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // data falls while the clock is high
    task automatic start_c();
        scl = 1'b0;
        tick(2);
        sda_low = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
    endtask : start_c
    // data rises while the clock is high, clock then stands high
    task automatic stop_c();
        scl = 1'b0;
        tick(2);
        sda_low = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask : stop_c
    // one bit: data moves only in the clock low phase
    task automatic send_bit(input logic b);
        scl = 1'b0;
        tick(2);
        sda_low = ~b;
        tick(2);
        scl = 1'b1;
        tick(4);
    endtask : send_bit
    // eight bits msb first, then the ninth clock samples the answer
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        scl = 1'b0;
        tick(2);
        sda_low = 1'b0; // release for the device's answer
        tick(2);
        scl = 1'b1;
        tick(2);
        ack = ~sda_line;
        tick(2);
    endtask : send_byte
endmodule : eeprom_bus_master
`default_nettype wire

// [eeprom_wr_pkg.sv]
// shared constants, state codes and event carrier of the two-wire eeprom write slave
package eeprom_wr_pkg;
    localparam int CLK_PERIOD_NS = 40;                      // ref_clk period, 25 mhz
    localparam int T_WR_NS = 5_000_000;                     // longest self-timed program cycle
    localparam int WR_CYCLES = T_WR_NS / CLK_PERIOD_NS;     // longest time, rounded down
    localparam int ADDR_W = 15;                             // word_address_bits width
    localparam int PAGE_W = 6;                              // in-page offset width
    localparam int PAGE_BYTES = 64;                         // bytes in one page
    localparam logic [3:0] ACK_BIT_CNT = 4'h8;              // bits in one word before ack slot
    localparam logic [3:0] TYPE_ARRAY = 4'ha;               // type nibble of the main array
    localparam logic [3:0] TYPE_ID = 4'hb;                  // type nibble of the id page
    localparam int TYPE_ID_BIT = 4;                         // bit that tells id from array
    localparam int LOCK_SEL_BIT = 10;                       // id_page_lock_select_bit position
    localparam int LOCK_DATA_BIT = 1;                       // data bit that requests the lock
    localparam logic [15:0] WORD_RST = 16'h0000;            // word address after reset
    localparam logic [7:0] BYTE_RST = 8'h00;                // shift and peek data after reset

    // one-hot transfer states
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_DEVADR = 6'h02,
        ST_ADRHI  = 6'h04,
        ST_ADRLO  = 6'h08,
        ST_DATA   = 6'h10,
        ST_IGNORE = 6'h20
    } xfer_state_e;

    // bus events found by the sampler, each a one-cycle pulse
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } bus_evt_s;
endpackage : eeprom_wr_pkg

// [eeprom_wr_slave.sv]
// two-wire eeprom write slave: framing, addressing, page buffer, program cycle, id page
// Functional notes
// R01 - master changes data only while clock low
// R02 - falling data, clock high: start, always detected
// R03 - rising data, clock high: stop, standby
// R04 - msb-first bytes, acknowledge low in ninth clock
// R05 - standby after reset, stop, program end
// R06 - start, nine clocks, start, stop recovers
// R07 - device word opens with one-zero nibble
// R08 - three address bits match chip-select straps
// R09 - eighth address bit: one read, zero write
// R10 - match acknowledges; mismatch ignores rest of transfer
// R11 - write inhibit high blocks all writes
// R12 - byte write: device, two address, data
// R13 - stop starts program cycle, bus ignored
// R14 - program time counted from the stop
// R15 - page write: more data bytes before stop
// R16 - increment six low address bits only
// R17 - over 64 bytes wrap and overwrite
// R18 - polling acknowledged only after programming ends
// R19 - extra 64-byte id page, lockable
// R20 - id write: type 1011b, bit10 zero
// R21 - locked id page: data not acknowledged
// R22 - lock command: bit10 one, data bit1
// R23 - data line released except when acknowledging
// R24 - inhibited data not acknowledged, no program
`timescale 1ns/1ps
`default_nettype none
module eeprom_wr_slave
    import eeprom_wr_pkg::*;
#(
    parameter int WR_CYCLES_P = WR_CYCLES  // program cycle length in ref_clk cycles
) (
    input wire logic ref_clk,                    // 25 mhz block clock
    input wire logic rst_n,                      // async reset, active low
    input wire logic scl_in,                     // serial clock pin, async
    input wire logic sda_in,                     // serial data pin level, async
    output logic sda_out,                        // data pin drive value, always low
    output logic sda_oe,                         // high while pulling data low
    input wire logic chip_select_strap_0,        // address strap bit 0
    input wire logic chip_select_strap_1,        // address strap bit 1
    input wire logic chip_select_strap_2,        // address strap bit 2
    input wire logic write_inhibit_pin,          // high blocks writes
    input wire logic peek_id,                    // peek port selects the id page
    input wire logic [ADDR_W-1:0] peek_addr,     // peek port byte address
    output logic [7:0] peek_data,                // peek port data, registered
    output logic prog_busy,                      // program cycle running
    output logic standby,                        // idle and not programming
    output logic id_locked                       // id page locked until reset
);
    // synchronisers: first stage feeds only the second
    logic [1:0] scl_s_q;                         // clock pin sync
    logic [1:0] sda_s_q;                         // data pin sync
    logic [1:0] wi_s_q;                          // inhibit pin sync
    logic [2:0] strap_s1_q;                      // strap first stage
    logic [2:0] strap_q;                         // strap second stage
    logic scl_p_q;                               // synced clock, one cycle late
    logic sda_p_q;                               // synced data, one cycle late
    bus_evt_s evt;                               // edge and condition pulses
    // transfer state
    xfer_state_e state_q;                        // current transfer phase
    xfer_state_e state_d;                        // phase after the ack slot
    logic [3:0] bit_cnt_q;                       // bits received in this word
    logic ack_phase_q;                           // inside the ninth clock
    logic ack_q;                                 // pulling data low
    logic ack_d;                                 // decision for the coming slot
    logic [7:0] shift_q;                         // received word, msb first
    logic is_id_q;                               // transfer targets the id page
    logic [15:0] word_q;                         // received word address
    logic [PAGE_W-1:0] off_q;                    // in-page offset
    logic slot_end;                              // eighth bit done, ack slot starts
    logic dev_match;                             // device word is ours
    logic lock_sel;                              // id write is a lock command
    logic accept_data;                           // data byte goes to page buffer
    logic accept_lock;                           // data byte may request the lock
    // page buffer and program cycle
    logic [7:0] buf_mem [0:PAGE_BYTES-1];        // bytes waiting for programming
    logic [PAGE_BYTES-1:0] buf_vld_q;            // which buffer bytes are written
    logic lock_pend_q;                           // lock requested in this write
    logic pending;                               // something to program
    logic busy_q;                                // program cycle running
    logic [31:0] prog_cnt_q;                     // cycles since the stop
    logic [PAGE_W:0] commit_idx_q;               // buffer entry being committed
    logic prog_start;                            // valid stop ends a write
    logic prog_done;                             // last cycle of programming
    logic locked_q;                              // id page lock state
    logic standby_q;                             // low-power state flag
    logic [7:0] mem [0:(1<<ADDR_W)-1];           // main array
    logic [7:0] id_mem [0:PAGE_BYTES-1];         // identification page
    // pin synchronisers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            wi_s_q <= 2'h0;
            strap_s1_q <= 3'h0;
            strap_q <= 3'h0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            wi_s_q <= {wi_s_q[0], write_inhibit_pin};
            strap_s1_q <= {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
            strap_q <= strap_s1_q;
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end
    // conditions: data moving while clock high is framing, never data
    always_comb begin
        evt.start = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];    // see R01 see R02
        evt.stop = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];     // see R03
        evt.scl_rise = scl_s_q[1] & ~scl_p_q;
        evt.scl_fall = ~scl_s_q[1] & scl_p_q;
    end
    assign slot_end = evt.scl_fall & ~ack_phase_q & (bit_cnt_q == ACK_BIT_CNT);
    assign dev_match = ((shift_q[7:4] == TYPE_ARRAY) || (shift_q[7:4] == TYPE_ID))
                       && (shift_q[3:1] == strap_q);                 // see R07 see R08
    assign lock_sel = is_id_q & word_q[LOCK_SEL_BIT];                // see R20 see R22
    assign pending = (|buf_vld_q) | lock_pend_q;
    // acknowledge decision and next phase at the end of each word
    always_comb begin
        ack_d = 1'b0;
        state_d = state_q;
        unique case (state_q)
            ST_IDLE, ST_IGNORE: begin
                ack_d = 1'b0;                                        // see R23
            end
            ST_DEVADR: begin
                // busy device stays silent to polls until programming ends
                if (dev_match && !busy_q) begin                      // see R18
                    ack_d = 1'b1;                                    // see R10
                    state_d = shift_q[0] ? ST_IGNORE : ST_ADRHI;     // see R09
                end else begin
                    state_d = ST_IGNORE;                             // see R10
                end
            end
            ST_ADRHI: begin
                ack_d = 1'b1;                                        // see R12
                state_d = ST_ADRLO;
            end
            ST_ADRLO: begin
                ack_d = 1'b1;                                        // see R12
                state_d = ST_DATA;
            end
            ST_DATA: begin
                // inhibit and a locked id page refuse the data byte
                ack_d = ~wi_s_q[1] & ~(is_id_q & locked_q);          // see R11 see R21 see R24
            end
        endcase
    end
    assign accept_data = slot_end & (state_q == ST_DATA) & ack_d & ~lock_sel;
    assign accept_lock = slot_end & (state_q == ST_DATA) & ack_d & lock_sel;
    // bit counter, shifter and acknowledge drive
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 4'h0;
            ack_phase_q <= 1'b0;
            ack_q <= 1'b0;
            shift_q <= BYTE_RST;
        end else if (evt.start || evt.stop) begin
            // framing restarts word alignment, also for soft reset
            bit_cnt_q <= 4'h0;                                       // see R06
            ack_phase_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (evt.scl_rise && !ack_phase_q && bit_cnt_q != ACK_BIT_CNT) begin
            shift_q <= {shift_q[6:0], sda_s_q[1]};                   // see R04
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end else if (evt.scl_fall && ack_phase_q) begin
            ack_phase_q <= 1'b0;                                     // see R23
            ack_q <= 1'b0;
        end else if (slot_end) begin
            bit_cnt_q <= 4'h0;
            ack_phase_q <= 1'b1;
            ack_q <= ack_d;                                          // see R04
        end
    end
    // transfer phase and address registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;                                      // see R05
            is_id_q <= 1'b0;
            word_q <= WORD_RST;
            off_q <= '0;
        end else if (evt.start) begin
            state_q <= ST_DEVADR;                                    // see R02
        end else if (evt.stop) begin
            state_q <= ST_IDLE;                                      // see R03
        end else if (slot_end) begin
            state_q <= state_d;
            if (state_q == ST_DEVADR && ack_d) begin
                is_id_q <= shift_q[TYPE_ID_BIT];                     // see R19
            end
            if (state_q == ST_ADRHI) begin
                word_q[15:8] <= shift_q;
            end
            if (state_q == ST_ADRLO) begin
                word_q[7:0] <= shift_q;
                off_q <= shift_q[PAGE_W-1:0];                        // see R20
            end
            if (accept_data) begin
                off_q <= off_q + 6'h01;                              // see R16 see R17
            end
        end
    end
    // page buffer contents, later bytes overwrite earlier ones
    always_ff @(posedge ref_clk) begin
        if (accept_data) begin
            buf_mem[off_q] <= shift_q;                               // see R15 see R17
        end
    end
    // buffer valid bits and lock request
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_vld_q <= '0;
            lock_pend_q <= 1'b0;
        end else if (prog_done || (evt.start && !busy_q)) begin
            // an unfinished write is dropped by the next start
            buf_vld_q <= '0;
            lock_pend_q <= 1'b0;
        end else if (accept_data) begin
            buf_vld_q[off_q] <= 1'b1;
        end else if (accept_lock) begin
            lock_pend_q <= shift_q[LOCK_DATA_BIT];                   // see R22
        end
    end
    assign prog_start = evt.stop & (state_q == ST_DATA) & pending & ~busy_q;
    assign prog_done = busy_q & (prog_cnt_q == 32'(WR_CYCLES_P - 1));
    // self-timed program cycle, timed from the stop
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            prog_cnt_q <= '0;
            commit_idx_q <= '0;
        end else if (prog_start) begin
            busy_q <= 1'b1;                                          // see R13
            prog_cnt_q <= '0;                                        // see R14
            commit_idx_q <= '0;
        end else if (prog_done) begin
            busy_q <= 1'b0;                                          // see R14
        end else if (busy_q) begin
            prog_cnt_q <= prog_cnt_q + 32'h1;
            if (!commit_idx_q[PAGE_W]) begin
                commit_idx_q <= commit_idx_q + 7'h01;
            end
        end
    end
    // commit one buffered byte per cycle while programming
    always_ff @(posedge ref_clk) begin
        if (busy_q && !commit_idx_q[PAGE_W] && buf_vld_q[commit_idx_q[PAGE_W-1:0]]) begin
            if (is_id_q) begin
                id_mem[commit_idx_q[PAGE_W-1:0]] <= buf_mem[commit_idx_q[PAGE_W-1:0]];
            end else begin
                mem[{word_q[ADDR_W-1:PAGE_W], commit_idx_q[PAGE_W-1:0]}] <=
                    buf_mem[commit_idx_q[PAGE_W-1:0]];               // see R16
            end
        end
    end
    // id page lock, held until the next rst_n reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_q <= 1'b0;
        end else if (prog_done && lock_pend_q) begin
            locked_q <= 1'b1;                                        // see R22
        end
    end
    // standby flag and peek port
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_q <= 1'b1;                                       // see R05
            peek_data <= BYTE_RST;
        end else begin
            standby_q <= ((state_q == ST_IDLE) || (state_q == ST_IGNORE)) && !busy_q;
            peek_data <= peek_id ? id_mem[peek_addr[PAGE_W-1:0]] : mem[peek_addr];
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = ack_q;
    assign prog_busy = busy_q;
    assign standby = standby_q;
    assign id_locked = locked_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_release_outside_slot;
        sda_oe |-> ack_phase_q;
    endproperty
    a_release_outside_slot: assert property (p_release_outside_slot) // see R23
        else $error("data line driven outside an ack slot");
    property p_silent_while_busy;
        busy_q |-> !sda_oe;
    endproperty
    a_silent_while_busy: assert property (p_silent_while_busy) // see R13
        else $error("acknowledge given during program cycle");
    property p_start_restarts;
        evt.start |=> (state_q == ST_DEVADR) && (bit_cnt_q == 4'h0) && !sda_oe;
    endproperty
    a_start_restarts: assert property (p_start_restarts) // see R02
        else $error("start did not restart the transfer");
    property p_mismatch_ignored;
        slot_end && (state_q == ST_DEVADR) && !dev_match |=> (state_q == ST_IGNORE) && !ack_q;
    endproperty
    a_mismatch_ignored: assert property (p_mismatch_ignored) // see R10
        else $error("foreign device address was answered");
    property p_match_acked;
        slot_end && (state_q == ST_DEVADR) && dev_match && !busy_q && !evt.start
        |=> ack_q && ack_phase_q;
    endproperty
    a_match_acked: assert property (p_match_acked) // see R10
        else $error("own device address not acknowledged");
    property p_inhibit_refuses;
        slot_end && (state_q == ST_DATA) && wi_s_q[1] |=> !ack_q && $stable(buf_vld_q);
    endproperty
    a_inhibit_refuses: assert property (p_inhibit_refuses) // see R24
        else $error("inhibited data byte accepted");
    property p_locked_refuses;
        slot_end && (state_q == ST_DATA) && is_id_q && locked_q |=> !ack_q;
    endproperty
    a_locked_refuses: assert property (p_locked_refuses) // see R21
        else $error("locked id page data acknowledged");
    property p_offset_wraps;
        accept_data && !evt.start && !evt.stop
        |=> off_q == $past(off_q) + 6'h01 ##0 word_q[15:PAGE_W] == $past(word_q[15:PAGE_W]);
    endproperty
    a_offset_wraps: assert property (p_offset_wraps) // see R16
        else $error("page offset did not step within the page");
    property p_stop_programs;
        prog_start |=> busy_q && (prog_cnt_q == 32'h0) ##1 busy_q[*8];
    endproperty
    a_stop_programs: assert property (p_stop_programs) // see R13
        else $error("program cycle did not start and hold after stop");
    property p_prog_length;
        busy_q && (prog_cnt_q == 32'(WR_CYCLES_P - 1)) |=> !busy_q ##1 standby_q;
    endproperty
    a_prog_length: assert property (p_prog_length) // see R14
        else $error("program cycle length wrong or no standby after it");
endmodule : eeprom_wr_slave
`default_nettype wire

// [test_eeprom_wr_slave.sv]
// self-checking bench of the two-wire eeprom write slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, (a), (b)); end end
module test_eeprom_wr_slave
    import eeprom_wr_pkg::*;
;
    localparam int WR_T = 200;           // shortened program cycle
    localparam logic [2:0] STRAP = 3'h5; // strap setting of this device
    logic [2:0] strap;                   // strap pins, moved away and back once at run time
    logic ref_clk, rst_n, inhibit, peek_id; // clock, reset and control inputs
    logic scl, sda_low, sda_oe, sda_out;    // bus pins
    logic [14:0] peek_addr;                 // inspection address
    logic [7:0] peek_data;                  // inspection data
    logic prog_busy, standby, id_locked;    // status outputs
    int miscompares = 0;                    // mismatch count
    int tests_run = 0;                      // comparison count
    wire sda_line = !(sda_low || (sda_oe && !sda_out)); // open drain with pull-up
    eeprom_wr_slave #(.WR_CYCLES_P(WR_T)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
        .chip_select_strap_2(strap[2]), .write_inhibit_pin(inhibit), .peek_id(peek_id),
        .peek_addr(peek_addr), .peek_data(peek_data), .prog_busy(prog_busy),
        .standby(standby), .id_locked(id_locked));
    eeprom_bus_master m_u (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
        .sda_low(sda_low));
    // 25 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // device word: type nibble, straps, read/write bit
    function automatic logic [7:0] dw(input logic [3:0] t, input logic [2:0] s, input logic r);
        return {t, s, r};
    endfunction : dw
    // write frame: device word, two address bytes, n data bytes counting up from d0
    task automatic wr_frame(input logic [3:0] t, input logic [15:0] a, input int n,
                            input logic [7:0] d0, input logic dack);
        logic ack;
        m_u.start_c();
        m_u.send_byte(dw(t, STRAP, 1'b0), ack);
        `CHK(ack, 1'b1)
        m_u.send_byte(a[15:8], ack);
        `CHK(ack, 1'b1)
        m_u.send_byte(a[7:0], ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < n; i++) begin
            m_u.send_byte(d0 + 8'(i), ack);
            `CHK(ack, dack)
        end
        m_u.stop_c();
        m_u.tick(8);
    endtask : wr_frame
    // bounded wait for the program cycle to end, n counts its cycles
    task automatic wait_idle(output int n);
        n = 0;
        while (prog_busy !== 1'b0 && n < 4 * WR_T) begin
            m_u.tick(1);
            n++;
        end
        m_u.tick(2);
        `CHK(prog_busy, 1'b0)
    endtask : wait_idle
    // registered inspection read
    task automatic peek(input logic id, input logic [14:0] a, output logic [7:0] d);
        peek_id = id;
        peek_addr = a;
        m_u.tick(2);
        d = peek_data;
    endtask : peek
    // foreign straps, bad type nibble, read word
    task automatic t_addr();
        logic ack;
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, STRAP ^ 3'h1, 1'b0), ack);
        `CHK(ack, 1'b0)
        m_u.send_byte(8'h00, ack);
        `CHK(ack, 1'b0)
        m_u.start_c();
        m_u.send_byte(dw(4'h5, STRAP, 1'b0), ack);
        `CHK(ack, 1'b0)
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, STRAP, 1'b1), ack);
        `CHK(ack, 1'b1)
        m_u.stop_c();
        `CHK(standby, 1'b1)
        // moved straps: the old address is foreign, the new one answers
        strap = 3'h2;
        m_u.tick(4);
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, STRAP, 1'b0), ack);
        `CHK(ack, 1'b0)
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, 3'h2, 1'b0), ack);
        `CHK(ack, 1'b1)
        m_u.stop_c();
        strap = STRAP;
        m_u.tick(4);
    endtask : t_addr
    // byte write with polling during and after the program cycle
    task automatic t_byte();
        logic ack;
        logic [7:0] d;
        int n;
        wr_frame(TYPE_ARRAY, 16'h1234, 1, 8'ha5, 1'b1);
        `CHK(prog_busy, 1'b1)
        `CHK(standby, 1'b0)
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, STRAP, 1'b0), ack);
        `CHK(ack, 1'b0)
        m_u.stop_c();
        wait_idle(n);
        `CHK(standby, 1'b1)
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, STRAP, 1'b0), ack);
        `CHK(ack, 1'b1)
        m_u.stop_c();
        peek(1'b0, 15'h1234, d);
        `CHK(d, 8'ha5)
    endtask : t_byte
    // 66 bytes from offset 62: wrap within the page and overwrite
    task automatic t_page();
        logic [7:0] d;
        int n;
        wr_frame(TYPE_ARRAY, 16'h0abe, PAGE_BYTES + 2, 8'h00, 1'b1);
        wait_idle(n);
        `CHK(n >= WR_T - 12 && n <= WR_T, 1'b1)
        peek(1'b0, 15'h0abe, d);
        `CHK(d, 8'h40)
        peek(1'b0, 15'h0a80, d);
        `CHK(d, 8'h02)
    endtask : t_page
    // write inhibit refuses data and starts no program cycle
    task automatic t_inhibit();
        logic [7:0] d;
        inhibit = 1'b1;
        m_u.tick(4);
        wr_frame(TYPE_ARRAY, 16'h1234, 1, 8'h5a, 1'b0);
        `CHK(prog_busy, 1'b0)
        peek(1'b0, 15'h1234, d);
        `CHK(d, 8'ha5)
        inhibit = 1'b0;
    endtask : t_inhibit
    // id page write, lock, then refused write
    task automatic t_id();
        logic [7:0] d;
        int n;
        wr_frame(TYPE_ID, 16'h7805, 1, 8'h3c, 1'b1);
        wait_idle(n);
        peek(1'b1, 15'h0005, d);
        `CHK(d, 8'h3c)
        wr_frame(TYPE_ID, 16'h0400, 1, 8'h02, 1'b1);
        wait_idle(n);
        `CHK(id_locked, 1'b1)
        wr_frame(TYPE_ID, 16'h0005, 1, 8'hc3, 1'b0);
        `CHK(prog_busy, 1'b0)
        peek(1'b1, 15'h0005, d);
        `CHK(d, 8'h3c)
    endtask : t_id
    // broken frame, then start, nine clocks, start, stop
    task automatic t_soft();
        logic ack;
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, STRAP, 1'b0), ack);
        m_u.start_c();
        for (int i = 0; i < 9; i++) begin
            m_u.send_bit(1'b1);
        end
        m_u.start_c();
        m_u.stop_c();
        m_u.start_c();
        m_u.send_byte(dw(TYPE_ARRAY, STRAP, 1'b0), ack);
        `CHK(ack, 1'b1)
        m_u.stop_c();
    endtask : t_soft
    // counts and verdict, then end
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // cuts a hang short
    initial begin
        #(40 * 60000);
        miscompares++;
        results();
    end
    // reset, then the scenarios
    initial begin
        rst_n = 1'b0;
        strap = STRAP;
        inhibit = 1'b0;
        peek_id = 1'b0;
        peek_addr = 15'h0000;
        m_u.tick(12);
        rst_n = 1'b1;
        m_u.tick(4);
        `CHK(standby, 1'b1)
        `CHK(sda_oe, 1'b0)
        `CHK(sda_out, 1'b0)
        t_addr();
        t_byte();
        t_page();
        t_inhibit();
        t_id();
        t_soft();
        results();
    end
endmodule : test_eeprom_wr_slave
`default_nettype wire
